// *** include/remap_select_pkg.sv ***
// package: register map, field layout, pin location types for the remap block
package remap_select_pkg;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ROUTE_CTRL_OFFSET = 8'h04;
	localparam logic [7:0] SEL0_OFFSET       = 8'h08;
	localparam logic [7:0] SEL1_OFFSET       = 8'h0c;
	localparam logic [7:0] SEL2_OFFSET       = 8'h10;

	// ------------------------------------------------------------------
	// reset values and field layout
	// ------------------------------------------------------------------
	localparam logic [31:0] ROUTE_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SEL_RESET        = 32'h0000_0000;
	localparam logic [31:0] ROUTE_CTRL_MASK  = 32'h0000_00ff;
	localparam logic [31:0] SEL_MASK         = 32'h0000_ffff;
	localparam int SPI_ROUTE_BIT     = 0;
	localparam int TWO_WIRE_BIT      = 1;
	localparam int SERIAL_A_BIT      = 2;
	localparam int SERIAL_B_BIT      = 3;
	localparam int SERIAL_C_LSB      = 4;
	localparam int TIMER_ROUTE_LSB   = 6;
	localparam int SEL_FIELD_WIDTH   = 4;
	localparam int LINES_PER_REG     = 4;
	localparam int LINE_COUNT        = 12;
	localparam int PORT_WIDTH        = 16;

	// ------------------------------------------------------------------
	// two-bit route codes and port codes
	// ------------------------------------------------------------------
	localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
	localparam logic [1:0] ROUTE_PARTIAL = 2'h1;
	localparam logic [1:0] ROUTE_UNUSED  = 2'h2;
	localparam logic [1:0] ROUTE_FULL    = 2'h3;
	localparam logic [3:0] PORT_A = 4'h0;
	localparam logic [3:0] PORT_B = 4'h1;
	localparam logic [3:0] PORT_C = 4'h2;
	localparam logic [3:0] PORT_D = 4'h3;
	localparam logic [3:0] PORT_E = 4'h4;

	// ------------------------------------------------------------------
	// bus encodings
	// ------------------------------------------------------------------
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] port;
		logic [3:0] pin;
	} pinLoc_t;

	typedef struct packed {
		logic [1:0] advancedTimerRoute;
		logic [1:0] serialPortCRoute;
		logic       serialPortBRoute;
		logic       serialPortARoute;
		logic       twoWirePortRoute;
		logic       serialPeriphPortRoute;
	} routeCtrl_t;

	typedef struct packed {
		logic [PORT_WIDTH-1:0] e;
		logic [PORT_WIDTH-1:0] d;
		logic [PORT_WIDTH-1:0] c;
		logic [PORT_WIDTH-1:0] b;
		logic [PORT_WIDTH-1:0] a;
	} portPins_t;

	function automatic pinLoc_t loc(input logic [3:0] port, input logic [3:0] pin);
		loc.port = port;
		loc.pin  = pin;
	endfunction : loc

endpackage : remap_select_pkg

// *** hdl/line_source_mux.sv ***
// line source multiplexer: picks one port pin per interrupt line, registered
`timescale 1ns/1ps
module line_source_mux
	import remap_select_pkg::*;
#(
	parameter int LINES = LINE_COUNT
) (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire portPins_t                   pins,
	input  wire logic [LINES-1:0][3:0]       select,
	output logic      [LINES-1:0]            lineOut
);

	// reserved codes give a quiet low line rather than a random pin
	function automatic logic pickSource(input portPins_t p, input logic [3:0] code,
	                                    input int idx);
		logic r;
		r = 1'b0;
		case (code)
			PORT_A:  r = p.a[idx];
			PORT_B:  r = p.b[idx];
			PORT_C:  r = p.c[idx];
			PORT_D:  r = p.d[idx];
			PORT_E:  r = p.e[idx];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pickSource

	// ------------------------------------------------------------------
	// per-line selection
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lineOut <= '0;
		end else begin
			for (int i = 0; i < LINES; i++) begin
				lineOut[i] <= pickSource(pins, select[i], i);
			end
		end
	end

endmodule : line_source_mux

// *** hdl/alt_function_remap.sv ***
// alternate function remap control and interrupt line source selection
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - timer route 01 moves break, three outputs
// - timer route 11 puts everything on port E
// - serial C route 00 uses B10..B14
// - serial C route 01 moves three to C
// - serial C route 11 uses D8..D12
// - serial B bit picks A0-4 or D3-7
// - serial A bit picks A9/A10 or B6/B7
// - two-wire bit picks B6/B7 or B8/B9
// - peripheral bit picks port A or A15/B3-7
// - route fields change only on software writes
// - selector code picks port A to E
// - selector 0 at 0x08, lines 0-3
// - selector 1 at 0x0C, lines 4-7
// - selector 2 at 0x10, lines 8-11
// - timer route 00 keeps default pins
module alt_function_remap
	import remap_select_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	input  wire portPins_t   portPins,
	output logic      [LINE_COUNT-1:0] extLine,
	output pinLoc_t   [8:0]  timerPins,
	output pinLoc_t   [4:0]  serialCPins,
	output pinLoc_t   [4:0]  serialBPins,
	output pinLoc_t   [1:0]  serialAPins,
	output pinLoc_t   [1:0]  twoWirePins,
	output pinLoc_t   [5:0]  periphPins,
	output routeCtrl_t       routeState
);

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [31:0] routeCtrl;
	logic [31:0] sel0;
	logic [31:0] sel1;
	logic [31:0] sel2;
	logic [31:0] next_routeCtrl;
	logic [31:0] next_sel0;
	logic [31:0] next_sel1;
	logic [31:0] next_sel2;

	// ------------------------------------------------------------------
	// bus address phase capture
	// ------------------------------------------------------------------
	logic        dataWrite;
	logic        dataRead;
	logic [7:0]  dataAddr;
	logic        addrPhase;

	assign addrPhase = hsel && htrans[1] && hready;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dataWrite <= 1'b0;
			dataRead  <= 1'b0;
			dataAddr  <= 8'h00;
		end else begin
			// narrow writes are dropped: the selectors take whole words only
			dataWrite <= addrPhase && hwrite && (hsize == HSIZE_WORD);
			dataRead  <= addrPhase && !hwrite;
			if (addrPhase) begin
				dataAddr <= haddr[7:0];
			end
		end
	end

	// zero wait state slave, always OKAY
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// ------------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic hit,
	                                      input logic [31:0] wdata, input logic [31:0] mask);
		return hit ? (wdata & mask) : cur;
	endfunction : merge

	// ------------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------------
	// one decode per word, so the merge below stays a plain select
	logic        hitRoute;
	logic        hitSel0;
	logic        hitSel1;
	logic        hitSel2;

	assign hitRoute = dataWrite && (dataAddr == ROUTE_CTRL_OFFSET);
	assign hitSel0  = dataWrite && (dataAddr == SEL0_OFFSET);
	assign hitSel1  = dataWrite && (dataAddr == SEL1_OFFSET);
	assign hitSel2  = dataWrite && (dataAddr == SEL2_OFFSET);

	always_comb begin
		// only a bus write reaches these, nothing inside the block moves them
		next_routeCtrl = merge(routeCtrl, hitRoute,
		                       hwdata, ROUTE_CTRL_MASK);
		next_sel0 = merge(sel0, hitSel0,
		                  hwdata, SEL_MASK);
		next_sel1 = merge(sel1, hitSel1,
		                  hwdata, SEL_MASK);
		next_sel2 = merge(sel2, hitSel2,
		                  hwdata, SEL_MASK);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			routeCtrl <= ROUTE_CTRL_RESET;
		end else begin
			routeCtrl <= next_routeCtrl;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sel0 <= SEL_RESET;
			sel1 <= SEL_RESET;
			sel2 <= SEL_RESET;
		end else begin
			sel0 <= next_sel0;
			sel1 <= next_sel1;
			sel2 <= next_sel2;
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	// read value taken from the next state so a read right behind a
	// write to the same word already sees the new contents
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				ROUTE_CTRL_OFFSET: next_rdata = next_routeCtrl;
				SEL0_OFFSET:       next_rdata = next_sel0;
				SEL1_OFFSET:       next_rdata = next_sel1;
				SEL2_OFFSET:       next_rdata = next_sel2;
				default:           next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// route fields
	// ------------------------------------------------------------------
	routeCtrl_t route;

	always_comb begin
		route.advancedTimerRoute    = routeCtrl[TIMER_ROUTE_LSB +: 2];
		route.serialPortCRoute      = routeCtrl[SERIAL_C_LSB +: 2];
		route.serialPortBRoute      = routeCtrl[SERIAL_B_BIT];
		route.serialPortARoute      = routeCtrl[SERIAL_A_BIT];
		route.twoWirePortRoute      = routeCtrl[TWO_WIRE_BIT];
		route.serialPeriphPortRoute = routeCtrl[SPI_ROUTE_BIT];
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			routeState <= '0;
		end else begin
			routeState <= route;
		end
	end

	// ------------------------------------------------------------------
	// advanced timer placement
	// ------------------------------------------------------------------
	// order: trigger, ch0..ch3, break, complementary out0..out2
	// unused code 10 falls back to the default map: no pin floats
	always_ff @(posedge clk) begin
		if (!rstn) begin
			timerPins <= {loc(PORT_B, 4'hf), loc(PORT_B, 4'he), loc(PORT_B, 4'hd),
			              loc(PORT_B, 4'hc), loc(PORT_A, 4'hb), loc(PORT_A, 4'ha),
			              loc(PORT_A, 4'h9), loc(PORT_A, 4'h8), loc(PORT_A, 4'hc)};
		end else begin
			case (route.advancedTimerRoute)
				ROUTE_PARTIAL: begin
					timerPins <= {loc(PORT_B, 4'h1), loc(PORT_B, 4'h0),
					              loc(PORT_A, 4'h7), loc(PORT_A, 4'h6),
					              loc(PORT_A, 4'hb), loc(PORT_A, 4'ha),
					              loc(PORT_A, 4'h9), loc(PORT_A, 4'h8),
					              loc(PORT_A, 4'hc)};
				end
				ROUTE_FULL: begin
					timerPins <= {loc(PORT_E, 4'hc), loc(PORT_E, 4'ha),
					              loc(PORT_E, 4'h8), loc(PORT_E, 4'hf),
					              loc(PORT_E, 4'he), loc(PORT_E, 4'hd),
					              loc(PORT_E, 4'hb), loc(PORT_E, 4'h9),
					              loc(PORT_E, 4'h7)};
				end
				default: begin
					timerPins <= {loc(PORT_B, 4'hf), loc(PORT_B, 4'he),
					              loc(PORT_B, 4'hd), loc(PORT_B, 4'hc),
					              loc(PORT_A, 4'hb), loc(PORT_A, 4'ha),
					              loc(PORT_A, 4'h9), loc(PORT_A, 4'h8),
					              loc(PORT_A, 4'hc)};
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// serial port C placement
	// ------------------------------------------------------------------
	// order: tx, rx, clock, cts, rts
	always_ff @(posedge clk) begin
		if (!rstn) begin
			serialCPins <= {loc(PORT_B, 4'he), loc(PORT_B, 4'hd), loc(PORT_B, 4'hc),
			                loc(PORT_B, 4'hb), loc(PORT_B, 4'ha)};
		end else begin
			case (route.serialPortCRoute)
				ROUTE_PARTIAL: begin
					serialCPins <= {loc(PORT_B, 4'he), loc(PORT_B, 4'hd),
					                loc(PORT_C, 4'hc), loc(PORT_C, 4'hb),
					                loc(PORT_C, 4'ha)};
				end
				ROUTE_FULL: begin
					serialCPins <= {loc(PORT_D, 4'hc), loc(PORT_D, 4'hb),
					                loc(PORT_D, 4'ha), loc(PORT_D, 4'h9),
					                loc(PORT_D, 4'h8)};
				end
				default: begin
					serialCPins <= {loc(PORT_B, 4'he), loc(PORT_B, 4'hd),
					                loc(PORT_B, 4'hc), loc(PORT_B, 4'hb),
					                loc(PORT_B, 4'ha)};
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// single-bit routes
	// ------------------------------------------------------------------
	// serial B order: tx, rx, clock, cts, rts
	always_ff @(posedge clk) begin
		if (!rstn) begin
			serialBPins <= {loc(PORT_A, 4'h1), loc(PORT_A, 4'h0), loc(PORT_A, 4'h4),
			                loc(PORT_A, 4'h3), loc(PORT_A, 4'h2)};
		end else if (route.serialPortBRoute) begin
			serialBPins <= {loc(PORT_D, 4'h4), loc(PORT_D, 4'h3), loc(PORT_D, 4'h7),
			                loc(PORT_D, 4'h6), loc(PORT_D, 4'h5)};
		end else begin
			serialBPins <= {loc(PORT_A, 4'h1), loc(PORT_A, 4'h0), loc(PORT_A, 4'h4),
			                loc(PORT_A, 4'h3), loc(PORT_A, 4'h2)};
		end
	end

	// serial A order: tx, rx
	always_ff @(posedge clk) begin
		if (!rstn) begin
			serialAPins <= {loc(PORT_A, 4'ha), loc(PORT_A, 4'h9)};
		end else if (route.serialPortARoute) begin
			serialAPins <= {loc(PORT_B, 4'h7), loc(PORT_B, 4'h6)};
		end else begin
			serialAPins <= {loc(PORT_A, 4'ha), loc(PORT_A, 4'h9)};
		end
	end

	// two-wire order: clock, data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			twoWirePins <= {loc(PORT_B, 4'h7), loc(PORT_B, 4'h6)};
		end else if (route.twoWirePortRoute) begin
			twoWirePins <= {loc(PORT_B, 4'h9), loc(PORT_B, 4'h8)};
		end else begin
			twoWirePins <= {loc(PORT_B, 4'h7), loc(PORT_B, 4'h6)};
		end
	end

	// peripheral order: select, clock, miso, mosi, data2, data3
	always_ff @(posedge clk) begin
		if (!rstn) begin
			periphPins <= {loc(PORT_A, 4'h3), loc(PORT_A, 4'h2), loc(PORT_A, 4'h7),
			               loc(PORT_A, 4'h6), loc(PORT_A, 4'h5), loc(PORT_A, 4'h4)};
		end else if (route.serialPeriphPortRoute) begin
			periphPins <= {loc(PORT_B, 4'h7), loc(PORT_B, 4'h6), loc(PORT_B, 4'h5),
			               loc(PORT_B, 4'h4), loc(PORT_B, 4'h3),
			               loc(PORT_A, 4'hf)};
		end else begin
			periphPins <= {loc(PORT_A, 4'h3), loc(PORT_A, 4'h2), loc(PORT_A, 4'h7),
			               loc(PORT_A, 4'h6), loc(PORT_A, 4'h5),
			               loc(PORT_A, 4'h4)};
		end
	end

	// ------------------------------------------------------------------
	// pin synchroniser and line selection
	// ------------------------------------------------------------------
	// two flops: pins are asynchronous to clk
	portPins_t pinMeta;
	portPins_t pinSync;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= portPins;
			pinSync <= pinMeta;
		end
	end

	logic [LINE_COUNT-1:0][3:0] lineSelect;

	// lines 0-3, 4-7, 8-11 from the three selector words, nibble by nibble
	assign lineSelect = {sel2[15:0], sel1[15:0], sel0[15:0]};

	// codes above 0100 give a low line; software keeps clear of them
	line_source_mux #(
		.LINES   (LINE_COUNT)
	) lineMux (
		.clk     (clk),
		.rstn    (rstn),
		.pins    (pinSync),
		.select  (lineSelect),
		.lineOut (extLine)
	);

endmodule : alt_function_remap

// *** bench/port_pins_model.sv ***
// model of the port pin levels: one port held high, all others low
`timescale 1ns/1ps
module port_pins_model
	import remap_select_pkg::*;
(
	input  wire logic [2:0] hotPort,
	output portPins_t       pins
);
	// --------------------------------------------
	// pin levels
	// --------------------------------------------
	// whole ports at one level, so a wrong port code shows as a wrong line
	always_comb begin
		pins.a = {PORT_WIDTH{hotPort == 3'h0}};
		pins.b = {PORT_WIDTH{hotPort == 3'h1}};
		pins.c = {PORT_WIDTH{hotPort == 3'h2}};
		pins.d = {PORT_WIDTH{hotPort == 3'h3}};
		pins.e = {PORT_WIDTH{hotPort == 3'h4}};
	end
endmodule : port_pins_model

// *** bench/remap_properties.sv ***
// checker: route map and bus properties of the remap block
`timescale 1ns/1ps
module remap_checker
	import remap_select_pkg::*;
(
	input wire logic             clk,
	input wire logic             rstn,
	input wire logic             hsel,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic             hready,
	input wire logic [31:0]      hrdata,
	input wire pinLoc_t [8:0]    timerPins,
	input wire pinLoc_t [4:0]    serialCPins,
	input wire pinLoc_t [4:0]    serialBPins,
	input wire pinLoc_t [1:0]    serialAPins,
	input wire pinLoc_t [1:0]    twoWirePins,
	input wire pinLoc_t [5:0]    periphPins,
	input wire routeCtrl_t       routeState
);
	// --------------------------------------------
	// helpers
	// --------------------------------------------
	logic wrStart;
	logic rdStart;
	assign wrStart = hsel & htrans[1] & hwrite & hready;
	assign rdStart = hsel & htrans[1] & ~hwrite & hready;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// --------------------------------------------
	// properties
	// --------------------------------------------
	a_timer_default: assert property (routeState.advancedTimerRoute == 2'h0 |->
		timerPins[5] == 8'h1c && timerPins[8] == 8'h1f) else $error("timer default map wrong");
	a_timer_partial: assert property (routeState.advancedTimerRoute == 2'h1 |->
		timerPins[5] == 8'h06 && timerPins[7] == 8'h10) else $error("timer partial map wrong");
	a_timer_full: assert property (routeState.advancedTimerRoute == 2'h3 |->
		timerPins[0] == 8'h47 && timerPins[5] == 8'h4f) else $error("timer full map wrong");
	a_serc_full: assert property (routeState.serialPortCRoute == 2'h3 |->
		serialCPins[0] == 8'h38 && serialCPins[4] == 8'h3c) else $error("serial c map wrong");
	a_serb_map: assert property (serialBPins[0] ==
		(routeState.serialPortBRoute ? 8'h35 : 8'h02)) else $error("serial b map wrong");
	a_sera_map: assert property (serialAPins[1] ==
		(routeState.serialPortARoute ? 8'h17 : 8'h0a)) else $error("serial a map wrong");
	a_two_wire_map: assert property (twoWirePins[1] ==
		(routeState.twoWirePortRoute ? 8'h19 : 8'h17)) else $error("two-wire map wrong");
	a_periph_map: assert property (periphPins[0] ==
		(routeState.serialPeriphPortRoute ? 8'h0f : 8'h04)) else $error("periph map wrong");
	a_route_quiet: assert property (!$stable(routeState) |->
		$past(wrStart, 3)) else $error("route changed without a write");
	a_rdata_hold: assert property (!rdStart |=> $stable(hrdata))
		else $error("read data moved without a read");
endmodule : remap_checker
bind alt_function_remap remap_checker chk_i (.clk, .rstn, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .timerPins, .serialCPins, .serialBPins, .serialAPins, .twoWirePins,
	.periphPins, .routeState);

// *** bench/alt_function_remap_tb.sv ***
// testbench: register access, route maps and line selection of the remap block
`timescale 1ns/1ps
module alt_function_remap_tb
	import remap_select_pkg::*;
;
	logic clk, rstn, hsel, hwrite, hready, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize, hotPort;
	logic [LINE_COUNT-1:0] extLine;
	portPins_t portPins;
	pinLoc_t [8:0] timerPins;
	pinLoc_t [4:0] serialCPins, serialBPins;
	pinLoc_t [1:0] serialAPins, twoWirePins;
	pinLoc_t [5:0] periphPins;
	routeCtrl_t routeState;
	int miscompares, cmp_count;
	// line codes for lines 11..0, none above 0100
	localparam logic [47:0] CODES = 48'h1043_2104_3210;
	assign hready = hreadyout;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	alt_function_remap uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .portPins(portPins),
		.extLine(extLine), .timerPins(timerPins), .serialCPins(serialCPins),
		.serialBPins(serialBPins), .serialAPins(serialAPins), .twoWirePins(twoWirePins),
		.periphPins(periphPins), .routeState(routeState));
	port_pins_model pm (.hotPort(hotPort), .pins(portPins));
	// --------------------------------------------
	// tasks
	// --------------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait: a stuck slave ends the run instead of hanging it
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask : waitReady
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic [2:0] sz);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= sz;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		rd = hrdata;
	endtask : bus
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, HSIZE_WORD);
		chk(rd, exp);
	endtask : rdChk
	task automatic routeCase(input logic [7:0] v, input logic [31:0] e0, e1, e2);
		bus(1'b1, ROUTE_CTRL_OFFSET, {24'hffffff, v}, HSIZE_WORD);
		rdChk(ROUTE_CTRL_OFFSET, {24'h0, v});
		chk({24'h0, routeState}, {24'h0, v});
		chk({timerPins[0], timerPins[5], timerPins[6], timerPins[7]}, e0);
		chk({serialCPins[0], serialCPins[3], serialBPins[0], serialAPins[0]}, e1);
		chk({twoWirePins[0], periphPins[0], periphPins[1], timerPins[8]}, e2);
	endtask : routeCase
	function automatic logic [31:0] expLine(input logic [3:0] p);
		expLine = 32'h0;
		for (int i = 0; i < LINE_COUNT; i++) begin
			expLine[i] = (CODES[4*i +: 4] == p);
		end
	endfunction : expLine
	// --------------------------------------------
	// main sequence
	// --------------------------------------------
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		hotPort = 3'h0;
		miscompares = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdChk(ROUTE_CTRL_OFFSET, ROUTE_CTRL_RESET);
		rdChk(SEL0_OFFSET, SEL_RESET);
		rdChk(SEL1_OFFSET, SEL_RESET);
		rdChk(SEL2_OFFSET, SEL_RESET);
		rdChk(8'h14, 32'h0);
		chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
		$display("test reset done");
		routeCase(8'h00, 32'h0c1c1d1e, 32'h1a1d0209, 32'h1604051f);
		routeCase(8'h5f, 32'h0c060710, 32'h2a1d3516, 32'h180f1311);
		routeCase(8'hf0, 32'h474f484a, 32'h383b0209, 32'h1604054c);
		$display("test routes done");
		bus(1'b1, SEL0_OFFSET, 32'h1111, 3'h0);
		rdChk(SEL0_OFFSET, 32'h0);
		bus(1'b1, SEL0_OFFSET, {16'hffff, CODES[15:0]}, HSIZE_WORD);
		bus(1'b1, SEL1_OFFSET, {16'h0, CODES[31:16]}, HSIZE_WORD);
		bus(1'b1, SEL2_OFFSET, {16'h0, CODES[47:32]}, HSIZE_WORD);
		rdChk(SEL0_OFFSET, {16'h0, CODES[15:0]});
		rdChk(SEL1_OFFSET, {16'h0, CODES[31:16]});
		rdChk(SEL2_OFFSET, {16'h0, CODES[47:32]});
		for (int p = 0; p < 5; p++) begin
			hotPort <= p[2:0];
			repeat (5) @(posedge clk);
			chk({20'h0, extLine}, expLine(p[3:0]));
		end
		$display("test line select done");
		report_and_stop();
	end
endmodule : alt_function_remap_tb
